// ### rtcal_top.sv
// Alarm compare block: alarm registers, stop handshake, event and interrupt.
// Assumes live time fields and a one-second tick arrive synchronous to clk_in.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module rtcal_top (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rdata_out,
  input wire logic tick_in,
  input wire logic [6:0] time_sec_in,
  input wire logic [6:0] time_min_in,
  input wire logic [4:0] time_hrs_in,
  input wire logic time_pm_in,
  input wire logic [2:0] time_wday_in,
  input wire logic [5:0] time_date_in,
  input wire logic [4:0] time_month_in,
  output logic coding_bcd_out,
  output logic hour_mode_select_out,
  output logic alarm_active_out,
  output logic alarm_interrupt_event_out,
  output logic irq_out
);
  // Reset release through two flops
  logic rst_meta_ff, rst_sync_ff;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  logic rst_n;
  assign rst_n = rst_sync_ff;

  // Register state
  logic [15:0] sec_min_ff, nxt_sec_min;
  logic [15:0] hour_wday_ff, nxt_hour_wday;
  logic [15:0] date_month_ff, nxt_date_month;
  logic [15:0] time_ctrl_ff, nxt_time_ctrl;
  logic stopped_ff, nxt_stopped;
  logic [15:0] int_status_ff, nxt_int_status;
  logic [15:0] int_mask_ff, nxt_int_mask;
  logic [15:0] rdata_ff, nxt_rdata;
  logic match_prev_ff, nxt_match_prev;
  logic active_ff, nxt_active;
  logic event_ff, nxt_event;
  logic irq_ff, nxt_irq;

  logic match;
  logic rise;
  logic alarm_stop_control;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  rtcal_match u_match (
    .tgt_sec_in(sec_min_ff[rtcal_pkg::SEC_LSB +: 7]),
    .tgt_min_in(sec_min_ff[rtcal_pkg::MIN_LSB +: 7]),
    .tgt_hrs_in(hour_wday_ff[rtcal_pkg::HRS_LSB +: 5]),
    .tgt_pm_in(hour_wday_ff[rtcal_pkg::PM_BIT]),
    .tgt_wday_in(hour_wday_ff[rtcal_pkg::WDAY_LSB +: 4]),
    .tgt_date_in(date_month_ff[rtcal_pkg::DATE_LSB +: 6]),
    .tgt_month_in(date_month_ff[rtcal_pkg::MONTH_LSB +: 5]),
    .time_sec_in(time_sec_in),
    .time_min_in(time_min_in),
    .time_hrs_in(time_hrs_in),
    .time_pm_in(time_pm_in),
    .time_wday_in(time_wday_in),
    .time_date_in(time_date_in),
    .time_month_in(time_month_in),
    .bcd_in(time_ctrl_ff[rtcal_pkg::CODING_BIT]),
    .hour12_in(time_ctrl_ff[rtcal_pkg::HOUR_MODE_BIT]),
    .match_out(match)
  );

  // Register writes and stop handshake
  always_comb begin
    nxt_sec_min = sec_min_ff;
    nxt_hour_wday = hour_wday_ff;
    nxt_date_month = date_month_ff;
    nxt_time_ctrl = time_ctrl_ff;
    nxt_int_mask = int_mask_ff;
    if (wr_in && hit(addr_in, rtcal_pkg::OFS_SEC_MIN)) begin
      nxt_sec_min = wdata_in & rtcal_pkg::MASK_SEC_MIN;
    end
    if (wr_in && hit(addr_in, rtcal_pkg::OFS_HOUR_WDAY)) begin
      nxt_hour_wday = wdata_in & rtcal_pkg::MASK_HOUR_WDAY;
    end
    if (wr_in && hit(addr_in, rtcal_pkg::OFS_DATE_MONTH)) begin
      nxt_date_month = wdata_in & rtcal_pkg::MASK_DATE_MONTH;
    end
    if (wr_in && hit(addr_in, rtcal_pkg::OFS_TIME_CTRL)) begin
      nxt_time_ctrl = wdata_in & rtcal_pkg::MASK_TIME_CTRL_RW;
    end
    if (wr_in && hit(addr_in, rtcal_pkg::OFS_INT_MASK)) begin
      nxt_int_mask = wdata_in & rtcal_pkg::MASK_INT;
    end
  end

  assign alarm_stop_control = time_ctrl_ff[rtcal_pkg::STOP_CTRL_BIT];

  // Stopping takes hold at once so no false alarm slips out; restarting waits for the next
  // second boundary, so the status shows when the circuitry really runs again
  always_comb begin
    nxt_stopped = stopped_ff;
    if (alarm_stop_control) begin
      nxt_stopped = 1'b1;
    end else if (tick_in) begin
      nxt_stopped = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sec_min_ff <= rtcal_pkg::RST_SEC_MIN;
      hour_wday_ff <= rtcal_pkg::RST_HOUR_WDAY;
      date_month_ff <= rtcal_pkg::RST_DATE_MONTH;
      time_ctrl_ff <= rtcal_pkg::RST_TIME_CTRL;
      int_mask_ff <= rtcal_pkg::RST_INT_MASK;
      stopped_ff <= rtcal_pkg::RST_STOPPED;
    end else begin
      sec_min_ff <= nxt_sec_min;
      hour_wday_ff <= nxt_hour_wday;
      date_month_ff <= nxt_date_month;
      time_ctrl_ff <= nxt_time_ctrl;
      int_mask_ff <= nxt_int_mask;
      stopped_ff <= nxt_stopped;
    end
  end

  // Alarm condition, edge event, sticky status and interrupt
  assign rise = match && !match_prev_ff && !stopped_ff;

  always_comb begin
    nxt_match_prev = match && !stopped_ff;
    nxt_active = match && !stopped_ff;
    nxt_event = rise;
    nxt_int_status = int_status_ff;
    if (wr_in && hit(addr_in, rtcal_pkg::OFS_INT_STATUS)) begin
      nxt_int_status = int_status_ff & ~(wdata_in & rtcal_pkg::MASK_INT);
    end
    // Set after clear so an event in the clearing cycle is kept
    if (rise) begin
      nxt_int_status[rtcal_pkg::INT_ALARM_BIT] = 1'b1;
    end
    nxt_irq = |(nxt_int_status & int_mask_ff);
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      match_prev_ff <= 1'b0;
      active_ff <= 1'b0;
      event_ff <= 1'b0;
      int_status_ff <= 16'h0000;
      irq_ff <= 1'b0;
    end else begin
      match_prev_ff <= nxt_match_prev;
      active_ff <= nxt_active;
      event_ff <= nxt_event;
      int_status_ff <= nxt_int_status;
      irq_ff <= nxt_irq;
    end
  end

  // Read path: data one cycle after the strobe, zero elsewhere
  always_comb begin
    nxt_rdata = 16'h0000;
    if (rd_in) begin
      unique case (addr_in)
        rtcal_pkg::OFS_SEC_MIN: begin
          nxt_rdata = sec_min_ff;
        end
        rtcal_pkg::OFS_HOUR_WDAY: begin
          nxt_rdata = hour_wday_ff;
        end
        rtcal_pkg::OFS_DATE_MONTH: begin
          nxt_rdata = date_month_ff;
        end
        rtcal_pkg::OFS_TIME_CTRL: begin
          nxt_rdata = time_ctrl_ff;
          nxt_rdata[rtcal_pkg::STOPPED_STS_BIT] = stopped_ff;
        end
        rtcal_pkg::OFS_INT_STATUS: begin
          nxt_rdata = int_status_ff;
        end
        rtcal_pkg::OFS_INT_MASK: begin
          nxt_rdata = int_mask_ff;
        end
        default: begin
          nxt_rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 16'h0000;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_out = rdata_ff;
  assign coding_bcd_out = time_ctrl_ff[rtcal_pkg::CODING_BIT];
  assign hour_mode_select_out = time_ctrl_ff[rtcal_pkg::HOUR_MODE_BIT];
  assign alarm_active_out = active_ff;
  assign alarm_interrupt_event_out = event_ff;
  assign irq_out = irq_ff;
endmodule
`default_nettype wire

// ### rtcal_pkg.sv
// Constants for the alarm compare block: register offsets, field layout, reset values.
// Assumes one core clock, registers reached over a plain address/strobe port.
// Behaviour
// - All-ones target field matches any time value
// - Weekday target bits 11:8, 1111 every day
// - Event when all live targets equal time
// - Minutes target bits 14:8, reset zero
// - Seconds target bits 6:0, reset zero
// - Hours target bits 4:0, mode dependent range
// - Bit 5 PM flag compared in 12-hour mode
// - Month target bits 12:8, reset zero
// - Date target bits 5:0, reset zero
// - Alarm condition holds every matching second
// - Stop control bit 9 suppresses, resets one
// - Read-only bit 8 shows actually stopped
// - Bit 15 selects binary or BCD coding
// - Bit 14 selects 12-hour or 24-hour mode
`default_nettype none
package rtcal_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam logic [7:0] OFS_SEC_MIN = 8'h14;
  localparam logic [7:0] OFS_HOUR_WDAY = 8'h15;
  localparam logic [7:0] OFS_DATE_MONTH = 8'h16;
  localparam logic [7:0] OFS_TIME_CTRL = 8'h17;
  localparam logic [7:0] OFS_INT_STATUS = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h19;
  // Field positions
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 8;
  localparam int HRS_LSB = 0;
  localparam int PM_BIT = 5;
  localparam int WDAY_LSB = 8;
  localparam int DATE_LSB = 0;
  localparam int MONTH_LSB = 8;
  localparam int CODING_BIT = 15;
  localparam int HOUR_MODE_BIT = 14;
  localparam int STOP_CTRL_BIT = 9;
  localparam int STOPPED_STS_BIT = 8;
  localparam int INT_ALARM_BIT = 0;
  // Register masks: writable bits of each register
  localparam logic [15:0] MASK_SEC_MIN = 16'h7f7f;
  localparam logic [15:0] MASK_HOUR_WDAY = 16'h0f3f;
  localparam logic [15:0] MASK_DATE_MONTH = 16'h1f3f;
  localparam logic [15:0] MASK_TIME_CTRL_RW = 16'hc200;
  localparam logic [15:0] MASK_INT = 16'h0001;
  // Reset values
  localparam logic [15:0] RST_SEC_MIN = 16'h0000;
  localparam logic [15:0] RST_HOUR_WDAY = 16'h0000;
  localparam logic [15:0] RST_DATE_MONTH = 16'h0000;
  localparam logic [15:0] RST_TIME_CTRL = 16'h0200;
  localparam logic RST_STOPPED = 1'b1;
  localparam logic [15:0] RST_INT_MASK = 16'h0000;
  // Ignore codes
  localparam logic [6:0] IGN_7 = 7'h7f;
  localparam logic [5:0] IGN_6 = 6'h3f;
  localparam logic [4:0] IGN_5 = 5'h1f;
  localparam logic [3:0] IGN_4 = 4'hf;
endpackage
`default_nettype wire

// ### rtcal_match.sv
// Combinational compare of alarm targets against the live time.
// Assumes both sides use the same coding and hour mode.
`timescale 1ns/1ps
`default_nettype none
module rtcal_match (
  input wire logic [6:0] tgt_sec_in,
  input wire logic [6:0] tgt_min_in,
  input wire logic [4:0] tgt_hrs_in,
  input wire logic tgt_pm_in,
  input wire logic [3:0] tgt_wday_in,
  input wire logic [5:0] tgt_date_in,
  input wire logic [4:0] tgt_month_in,
  input wire logic [6:0] time_sec_in,
  input wire logic [6:0] time_min_in,
  input wire logic [4:0] time_hrs_in,
  input wire logic time_pm_in,
  input wire logic [2:0] time_wday_in,
  input wire logic [5:0] time_date_in,
  input wire logic [4:0] time_month_in,
  input wire logic bcd_in,
  input wire logic hour12_in,
  output logic match_out
);
  // BCD to binary on a seven-bit field; identity in binary coding
  function automatic logic [6:0] to_bin(input logic [6:0] v, input logic bcd);
    logic [6:0] tens;
    tens = {4'h0, v[6:4]};
    if (bcd) begin
      to_bin = 7'((tens << 3) + (tens << 1) + {3'h0, v[3:0]});
    end else begin
      to_bin = v;
    end
  endfunction

  logic sec_ok, min_ok, hrs_ok, wday_ok, date_ok, month_ok;

  always_comb begin
    sec_ok = (tgt_sec_in == rtcal_pkg::IGN_7) ||
             (to_bin(tgt_sec_in, bcd_in) == to_bin(time_sec_in, bcd_in));
    min_ok = (tgt_min_in == rtcal_pkg::IGN_7) ||
             (to_bin(tgt_min_in, bcd_in) == to_bin(time_min_in, bcd_in));
    hrs_ok = (tgt_hrs_in == rtcal_pkg::IGN_5) ||
             ((to_bin({2'h0, tgt_hrs_in}, bcd_in) == to_bin({2'h0, time_hrs_in}, bcd_in)) &&
              (!hour12_in || (tgt_pm_in == time_pm_in)));
    wday_ok = (tgt_wday_in == rtcal_pkg::IGN_4) || (tgt_wday_in == {1'b0, time_wday_in});
    date_ok = (tgt_date_in == rtcal_pkg::IGN_6) ||
              (to_bin({1'b0, tgt_date_in}, bcd_in) == to_bin({1'b0, time_date_in}, bcd_in));
    month_ok = (tgt_month_in == rtcal_pkg::IGN_5) ||
               (to_bin({2'h0, tgt_month_in}, bcd_in) == to_bin({2'h0, time_month_in}, bcd_in));
    match_out = sec_ok && min_ok && hrs_ok && wday_ok && date_ok && month_ok;
  end
endmodule
`default_nettype wire

// ### rtcal_top_sva.sv
// Port checker for the alarm compare block.
// Assumes one clock and the reset input seen at the top's ports.
`timescale 1ns/1ps
`default_nettype none
module rtcal_top_sva (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic [6:0] time_sec_in,
  input wire logic [6:0] time_min_in,
  input wire logic [4:0] time_hrs_in,
  input wire logic time_pm_in,
  input wire logic [2:0] time_wday_in,
  input wire logic [5:0] time_date_in,
  input wire logic [4:0] time_month_in,
  input wire logic coding_bcd_out,
  input wire logic hour_mode_select_out,
  input wire logic alarm_active_out,
  input wire logic alarm_interrupt_event_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire logic [33:0] tvec = {time_sec_in, time_min_in, time_hrs_in, time_pm_in, time_wday_in, time_date_in,
    time_month_in};
  wire logic ctl_wr = wr_in && addr_in == rtcal_pkg::OFS_TIME_CTRL;
  wire logic ctl_rd = rd_in && addr_in == rtcal_pkg::OFS_TIME_CTRL;
  evt_edge_a: assert property (alarm_interrupt_event_out == $rose(alarm_active_out))
    else $error("event not on rise of active");
  evt_cause_a: assert property (alarm_interrupt_event_out |-> alarm_active_out)
    else $error("event without active match");
  // Stopped status lands one edge after the control write and the active flop one more,
  // so active and event may still show for two cycles after the write
  stop_quiet_a: assert property (ctl_wr && wdata_in[9] |=>
    ##2 !alarm_active_out && !alarm_interrupt_event_out)
    else $error("alarm seen after stop");
  // A write two cycles back may be a stop that only now reaches the active flop
  hold_active_a: assert property (alarm_active_out && $stable(tvec) && !$past(wr_in) && !$past(wr_in, 2)
    |=> alarm_active_out)
    else $error("active dropped with steady time");
  mode_bits_a: assert property (ctl_wr |=> {coding_bcd_out, hour_mode_select_out} == $past(wdata_in[15:14]))
    else $error("mode outputs not written");
  ctl_read_a: assert property (ctl_rd |=> rdata_out[15:14] == {coding_bcd_out, hour_mode_select_out}
    && (rdata_out & 16'h3cff) == 16'h0000)
    else $error("control read wrong");
  sec_min_bits_a: assert property (rd_in && addr_in == rtcal_pkg::OFS_SEC_MIN |=> rdata_out[15] == 1'b0
    && rdata_out[7] == 1'b0)
    else $error("seconds minutes spare bits set");
  hour_bits_a: assert property (rd_in && addr_in == rtcal_pkg::OFS_HOUR_WDAY |=> rdata_out[15:12] == 4'h0
    && rdata_out[7:6] == 2'h0)
    else $error("hour weekday spare bits set");
  date_bits_a: assert property (rd_in && addr_in == rtcal_pkg::OFS_DATE_MONTH |=> rdata_out[15:13] == 3'h0
    && rdata_out[7:6] == 2'h0)
    else $error("date month spare bits set");
  cover property (alarm_interrupt_event_out && irq_out);
  cover property (alarm_active_out [*8]);
  cover property (rd_in && addr_in > 8'h19);
endmodule
bind rtcal_top rtcal_top_sva rtcal_top_sva_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
  .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .time_sec_in(time_sec_in),
  .time_min_in(time_min_in), .time_hrs_in(time_hrs_in), .time_pm_in(time_pm_in), .time_wday_in(time_wday_in),
  .time_date_in(time_date_in), .time_month_in(time_month_in), .coding_bcd_out(coding_bcd_out),
  .hour_mode_select_out(hour_mode_select_out), .alarm_active_out(alarm_active_out),
  .alarm_interrupt_event_out(alarm_interrupt_event_out), .irq_out(irq_out));
`default_nettype wire

// ### test_rtcal_top.sv
// Bench for the alarm compare block: register tasks and live time stimulus.
// Assumes reads answer one cycle late; weekday, date and month change only in the full match test.
`timescale 1ns/1ps
`default_nettype none
module test_rtcal_top;
  logic clk_in, reset_n_in, wr_in, rd_in, tick_in, pm, bcd, h12, act, evt, irq;
  logic [7:0] addr_in;
  logic [15:0] wdata_in, rdata_out;
  logic [6:0] sec, min;
  logic [4:0] hrs;
  logic [2:0] wday;
  logic [5:0] date;
  logic [4:0] month;
  int error_cnt, total_checks, cyc;
  rtcal_top rtcal_top_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .tick_in(tick_in), .time_sec_in(sec), .time_min_in(min),
    .time_hrs_in(hrs), .time_pm_in(pm), .time_wday_in(wday), .time_date_in(date), .time_month_in(month),
    .coding_bcd_out(bcd), .hour_mode_select_out(h12), .alarm_active_out(act), .alarm_interrupt_event_out(evt),
    .irq_out(irq));
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 chk(rdata_out, e);
  endtask
  // Outputs are registered: looked at one edge after the time changes
  task automatic tm(input logic [6:0] s, m, input logic [4:0] h, input logic p, input logic [2:0] e);
    @(posedge clk_in);
    sec <= s;
    min <= m;
    hrs <= h;
    pm <= p;
    @(posedge clk_in);
    #1 chk({13'h0, act, evt, irq}, {13'h0, e});
  endtask
  // Restart needs a tick before the stopped status clears
  task automatic go(input logic [15:0] c, input logic [2:0] e);
    wr(8'h17, c);
    @(posedge clk_in);
    tick_in <= 1'b1;
    @(posedge clk_in);
    tick_in <= 1'b0;
    @(posedge clk_in);
    #1 chk({13'h0, act, evt, irq}, {13'h0, e});
  endtask
  initial begin
    {reset_n_in, wr_in, rd_in, tick_in, pm, addr_in, wdata_in} = '0;
    {sec, min, hrs} = {7'h01, 7'h00, 5'h00};
    {wday, date, month} = {3'h3, 6'h0f, 5'h06};
    error_cnt = 0;
    total_checks = 0;
    repeat (2) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rd(8'h14, 16'h0000);
    rd(8'h15, 16'h0000);
    rd(8'h16, 16'h0000);
    rd(8'h17, 16'h0300);
    rd(8'h1a, 16'h0000);
    $display("Test reset values done");
    wr(8'h14, 16'hffff);
    rd(8'h14, 16'h7f7f);
    wr(8'h15, 16'hffff);
    rd(8'h15, 16'h0f3f);
    wr(8'h16, 16'hffff);
    rd(8'h16, 16'h1f3f);
    go(16'h0000, 3'b110);
    rd(8'h17, 16'h0000);
    rd(8'h18, 16'h0001);
    $display("Test ignore fields done");
    wr(8'h17, 16'h0200);
    rd(8'h17, 16'h0300);
    wr(8'h14, 16'h2238);
    wr(8'h15, 16'h030c);
    wr(8'h16, 16'h060f);
    wr(8'h18, 16'h0001);
    wr(8'h19, 16'h0001);
    tm(7'd56, 7'd34, 5'd12, 1'b0, 3'b000);
    tm(7'd55, 7'd34, 5'd12, 1'b0, 3'b000);
    go(16'h0000, 3'b000);
    tm(7'd56, 7'd34, 5'd12, 1'b0, 3'b111);
    tm(7'd56, 7'd34, 5'd12, 1'b0, 3'b101);
    @(posedge clk_in);
    wday <= 3'h4;
    tm(7'd56, 7'd34, 5'd12, 1'b0, 3'b001);
    @(posedge clk_in);
    {wday, date} <= {3'h3, 6'h10};
    tm(7'd56, 7'd34, 5'd12, 1'b0, 3'b001);
    @(posedge clk_in);
    {date, month} <= {6'h0f, 5'h07};
    tm(7'd56, 7'd34, 5'd12, 1'b0, 3'b001);
    // Month comes back with a minute change so no stray match slips in
    @(posedge clk_in);
    {month, min} <= {5'h06, 7'd35};
    tm(7'd56, 7'd35, 5'd12, 1'b0, 3'b001);
    wr(8'h18, 16'h0001);
    rd(8'h18, 16'h0000);
    $display("Test full match done");
    wr(8'h17, 16'h0200);
    wr(8'h14, 16'h227f);
    go(16'h0000, 3'b000);
    tm(7'd0, 7'd34, 5'd12, 1'b0, 3'b111);
    for (int s = 1; s < 60; s++)
      tm(7'(s), 7'd34, 5'd12, 1'b0, 3'b101);
    tm(7'd0, 7'd35, 5'd12, 1'b0, 3'b001);
    wr(8'h18, 16'h0001);
    wr(8'h19, 16'h0000);
    tm(7'd0, 7'd34, 5'd12, 1'b0, 3'b110);
    $display("Test minute alarm done");
    wr(8'h17, 16'h0200);
    wr(8'h15, 16'h0327);
    go(16'h4000, 3'b000);
    chk({15'h0, h12}, 16'h0001);
    tm(7'd0, 7'd34, 5'd7, 1'b0, 3'b000);
    tm(7'd0, 7'd34, 5'd7, 1'b1, 3'b110);
    $display("Test twelve hour done");
    wr(8'h17, 16'h0200);
    wr(8'h14, 16'h3459);
    wr(8'h15, 16'h0312);
    wr(8'h16, 16'h1f3f);
    go(16'h8000, 3'b000);
    chk({14'h0, bcd, h12}, 16'h0002);
    tm(7'h59, 7'h34, 5'h12, 1'b0, 3'b110);
    tm(7'h58, 7'h34, 5'h12, 1'b0, 3'b000);
    wr(8'h17, 16'h0200);
    tm(7'h59, 7'h34, 5'h12, 1'b0, 3'b000);
    $display("Test coding and stop done");
    stop_test();
  end
endmodule
`default_nettype wire
